// ===== hw/hpp_busy_timer.sv
`timescale 1ns/1ps
// ****************************************************************
// Busy timer that holds the port not ready after each strobe.
// ****************************************************************
module hpp_busy_timer #(
    parameter int COUNT = hpp_pkg::BUSY_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    hpp_evt_if.timer tif
);
    import hpp_pkg::*;
    typedef struct packed {
        logic [7:0] cnt;
    } hpp_tmr_s;
    hpp_tmr_s s_q, s_d; // Whole state of the timer.

    // A start reloads the count; otherwise it runs down to zero.
    always_comb
    begin
        s_d = s_q;
        if (tif.start)
        begin
            s_d.cnt = 8'(COUNT);
        end
        else if (s_q.cnt != 8'h00)
        begin
            s_d.cnt = s_q.cnt - 8'h01;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tif.busy = (s_q.cnt != 8'h00);

    a_busy_after_start : assert property (@(posedge clk) disable iff (!arst_n)
        tif.start |=> tif.busy)
        else $error("busy not raised after a strobe");
endmodule : hpp_busy_timer

// ===== hw/hpp_evt_if.sv
`timescale 1ns/1ps
// ****************************************************************
// Event, interrupt and busy signals between the core and its helpers.
// ****************************************************************
interface hpp_evt_if;
    import hpp_pkg::*;
    logic [NEV-1:0] evt; // One-cycle event pulses.
    logic wrStatus; // Write-one-to-clear strobe.
    logic wrMask; // Mask write strobe.
    logic [NEV-1:0] wdata; // Write data for both.
    logic [NEV-1:0] status; // Sticky status.
    logic [NEV-1:0] mask; // Mask bits.
    logic irq; // Summary interrupt.
    logic start; // Starts a busy period.
    logic busy; // Busy period running.
    modport core (output evt, wrStatus, wrMask, wdata, start,
        input status, mask, irq, busy);
    modport irqs (input evt, wrStatus, wrMask, wdata, output status, mask, irq);
    modport timer (input start, output busy);
endinterface : hpp_evt_if

// ===== hw/hpp_host_port.sv
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// ****************************************************************
// Host port core: pins, host registers, APB slave.
// ****************************************************************
// Summary of operation
// - Host exchanges data over shared data pins
// - Data pins float unless reading, and always when forced
// - Holders keep last level when undriven
// - Holders off at reset, software bit
// - Pull-ups on only when port disabled
// - Wide mode ignores register select
// - Address strobe latches the host address
// - Ready shows next transfer is accepted
// - Ready driven high during reset
// - Interrupt high in reset, unused wide
// - Ready and interrupt float when forced
// - Data pins serve as GPIO otherwise
// - Port strap sampled at reset release
module hpp_host_port (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [7:0] hostDataIn,
    output logic [7:0] hostDataOut,
    output logic [7:0] hostDataOeN,
    output logic holderEn,
    output logic [7:0] holderLevel,
    input wire logic hostRegisterSelect0,
    input wire logic hostRegisterSelect1,
    input wire logic byteOrderFlag,
    input wire logic portSelectN,
    input wire logic hostStrobeAN,
    input wire logic hostStrobeBN,
    input wire logic addrLatchStrobeN,
    input wire logic hostReadNotWrite,
    output logic portReadyOut,
    output logic portReadyOeN,
    output logic hostIrqOut,
    output logic hostIrqOeN,
    input wire logic floatAllN,
    input wire logic portEnableStrap,
    input wire logic wideModeStrap,
    output logic pullupEn
);
    import hpp_pkg::*;

    // ****************************************************************
    // State and helpers
    // ****************************************************************
    typedef struct packed {
        logic strapDone; // Straps have been caught after reset.
        logic portEn; // Host port selected by strap.
        logic wide; // Wide mode strap.
        logic holder; // Bus holder enable.
        logic hostIrq; // Interrupt towards the host pending.
        logic irqPin; // Registered level of the interrupt pin.
        logic strobeDly; // Previous combined strobe.
        logic alsDly; // Previous address strobe.
        logic drive; // Read data on the pins.
        logic [7:0] dout; // Read byte.
        logic [15:0] haddr; // Host address register.
        logic [15:0] toHost; // Word that software offers the host.
        logic [15:0] fromHost; // Word that the host wrote.
        logic [7:0] gpioOut; // GPIO output levels.
        logic [7:0] gpioDir; // GPIO directions, one means output.
        logic [7:0] lastLevel; // Last level seen on the pins.
        logic [31:0] prdata; // APB read data.
    } hpp_core_s;
    hpp_core_s s_q, s_d; // Whole state of the core.

    hpp_evt_if eif(); // Links to the helper modules.
    logic [1:0] sel; // Effective register select.
    logic strobeNow; // Combined strobe with select.
    logic take; // A strobe edge is accepted.
    logic alsFall; // Address strobe edge.
    logic apbWr; // APB write in access phase.
    logic apbSetup; // APB setup phase.
    logic mapped; // Address hits a register.
    logic [15:0] hword; // Host register word being read.
    logic [7:0] rbyte; // Byte of it that goes out.
    logic [7:0] wbyte; // Register byte lane mask for host writes.
    logic ackWr; // Host acknowledged the interrupt.

    hpp_irq_regs u_irq (
        .clk(clk),
        .arst_n(arst_n),
        .eif(eif)
    );
    hpp_busy_timer #(
        .COUNT(BUSY_CYC)
    ) u_tmr (
        .clk(clk),
        .arst_n(arst_n),
        .tif(eif)
    );

    // ****************************************************************
    // Host side decode
    // ****************************************************************
    // Strobes are active low; either one pulses while the other rests high.
    // Select must stay low the whole access, so a high select drops it.
    // select gates strobes
    assign strobeNow = s_q.portEn & ~portSelectN & (~hostStrobeAN | ~hostStrobeBN);
    assign take = strobeNow & ~s_q.strobeDly & ~eif.busy;
    assign alsFall = s_q.portEn & ~portSelectN & ~addrLatchStrobeN & ~s_q.alsDly;
    assign sel = s_q.wide ? SEL_DATA : {hostRegisterSelect1, hostRegisterSelect0};
    assign ackWr = take & ~hostReadNotWrite & (sel == SEL_CTRL) & hostDataIn[HCTRL_ACK];
    assign apbSetup = psel & ~penable;
    assign apbWr = psel & penable & pwrite;

    // Word the host reads for the selected register; code three reads data.
    always_comb
    begin
        case (sel)
            SEL_CTRL: hword = 16'(s_q.hostIrq);
            SEL_ADDR: hword = s_q.haddr;
            default: hword = s_q.toHost;
        endcase
        if (s_q.wide)
        begin
            rbyte = hword[7:0];
            wbyte = 8'h01;
        end
        else if (byteOrderFlag)
        begin
            rbyte = hword[7:0];
            wbyte = 8'h01;
        end
        else
        begin
            rbyte = hword[15:8];
            wbyte = 8'h02;
        end
    end

    // APB decode of mapped offsets; anything else answers with an error.
    always_comb
    begin
        case (paddr)
            OFF_CTRL, OFF_STATUS, OFF_MASK, OFF_HADDR: mapped = 1'b1;
            OFF_TOHOST, OFF_FROMHOST, OFF_GPIO: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.strobeDly = strobeNow;
        s_d.alsDly = s_q.portEn & ~portSelectN & ~addrLatchStrobeN;
        s_d.lastLevel = hostDataIn;
        if (!s_q.strapDone)
        begin
            s_d.strapDone = 1'b1;
            s_d.portEn = portEnableStrap;
            s_d.wide = wideModeStrap;
        end
        if (alsFall)
        begin
            if (wbyte[0])
            begin
                s_d.haddr[7:0] = hostDataIn;
            end
            else
            begin
                s_d.haddr[15:8] = hostDataIn;
            end
        end
        if (take & hostReadNotWrite)
        begin
            s_d.drive = 1'b1;
            s_d.dout = rbyte;
        end
        else if (!(strobeNow & hostReadNotWrite))
        begin
            s_d.drive = 1'b0;
        end
        // Host writes land in the selected register half.
        if (take & ~hostReadNotWrite & (sel == SEL_ADDR))
        begin
            if (wbyte[0])
            begin
                s_d.haddr[7:0] = hostDataIn;
            end
            else
            begin
                s_d.haddr[15:8] = hostDataIn;
            end
        end
        if (take & ~hostReadNotWrite & (sel != SEL_CTRL) & (sel != SEL_ADDR))
        begin
            if (wbyte[0])
            begin
                s_d.fromHost[7:0] = hostDataIn;
            end
            else
            begin
                s_d.fromHost[15:8] = hostDataIn;
            end
        end
        if (ackWr)
        begin
            s_d.hostIrq = 1'b0;
        end
        // APB writes; a software set wins over a same-cycle acknowledge.
        if (apbWr)
        begin
            case (paddr)
                OFF_CTRL:
                begin
                    s_d.holder = pwdata[CTRL_HOLDER];
                    if (pwdata[CTRL_HOSTIRQ])
                    begin
                        s_d.hostIrq = 1'b1;
                    end
                end
                OFF_TOHOST: s_d.toHost = pwdata[15:0];
                OFF_GPIO:
                begin
                    s_d.gpioOut = pwdata[GPIO_OUT_LSB +: 8];
                    s_d.gpioDir = pwdata[GPIO_DIR_LSB +: 8];
                end
                default: s_d.holder = s_d.holder;
            endcase
        end
        s_d.irqPin = ~(s_d.hostIrq & ~s_d.wide);
        // Read data is fixed in the setup phase so the access needs no wait.
        if (apbSetup)
        begin
            case (paddr)
                OFF_CTRL: s_d.prdata = {28'h0000000, s_q.wide, s_q.portEn, s_q.hostIrq,
                    s_q.holder};
                OFF_STATUS: s_d.prdata = 32'(eif.status);
                OFF_MASK: s_d.prdata = 32'(eif.mask);
                OFF_HADDR: s_d.prdata = 32'(s_q.haddr);
                OFF_TOHOST: s_d.prdata = 32'(s_q.toHost);
                OFF_FROMHOST: s_d.prdata = 32'(s_q.fromHost);
                OFF_GPIO: s_d.prdata = {8'h00, s_q.lastLevel, s_q.gpioDir, s_q.gpioOut};
                default: s_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    // State register; the interrupt pin idles high from reset.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
            s_q.irqPin <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Helpers and pins
    // ****************************************************************
    assign eif.evt[EV_HWRITE] = take & ~hostReadNotWrite & (sel == SEL_DATA) & wbyte[0];
    assign eif.evt[EV_HREAD] = take & hostReadNotWrite & (sel == SEL_DATA) & wbyte[0];
    assign eif.evt[EV_ACK] = ackWr;
    assign eif.evt[EV_ADDR] = alsFall;
    assign eif.wrStatus = apbWr & (paddr == OFF_STATUS);
    assign eif.wrMask = apbWr & (paddr == OFF_MASK);
    assign eif.wdata = pwdata[NEV-1:0];
    assign eif.start = take;

    assign prdata = s_q.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign irq = eif.irq;

    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_pin
            assign hostDataOut[i] = s_q.portEn ? s_q.dout[i] : s_q.gpioOut[i];
            assign hostDataOeN[i] = ~floatAllN
                | (s_q.portEn ? ~s_q.drive : ~s_q.gpioDir[i]);
        end
    endgenerate
    assign holderEn = s_q.holder & (&hostDataOeN);
    assign holderLevel = s_q.lastLevel;
    assign pullupEn = ~s_q.portEn;
    assign portReadyOut = ~eif.busy;
    assign portReadyOeN = ~floatAllN;
    assign hostIrqOeN = ~floatAllN;
    assign hostIrqOut = s_q.irqPin;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence readStart;
        take && hostReadNotWrite;
    endsequence
    sequence readHeld;
        strobeNow && hostReadNotWrite;
    endsequence

    a_read_drives_pins : assert property (readStart ##1 readHeld |-> s_q.drive)
        else $error("read strobe did not drive the pins");
    a_float_data_z : assert property (!floatAllN |-> (&hostDataOeN))
        else $error("data pins driven while forced to float");
    a_holder_idle : assert property (holderEn |-> (&hostDataOeN))
        else $error("holder on while pins driven");
    a_holder_reset_off : assert property (@(posedge clk) disable iff (1'b0)
        !arst_n |-> !holderEn)
        else $error("holder on during reset");
    a_pullup_strap : assert property ($rose(s_q.strapDone)
        |-> pullupEn == !$past(portEnableStrap))
        else $error("pull-up does not follow the port strap");
    a_wide_ignores_sel : assert property (s_q.wide && take && !hostReadNotWrite
        |=> $stable(s_q.haddr))
        else $error("wide mode wrote through the select lines");
    a_addr_latch_low : assert property (alsFall && byteOrderFlag && !s_q.wide
        |=> s_q.haddr[7:0] == $past(hostDataIn))
        else $error("address byte not latched");
    a_ready_reset_high : assert property (@(posedge clk) disable iff (1'b0)
        !arst_n |-> portReadyOut && hostIrqOut)
        else $error("ready or interrupt low during reset");
    a_float_ctl_z : assert property (!floatAllN |-> portReadyOeN && hostIrqOeN)
        else $error("ready or interrupt driven while forced to float");
    a_strap_frozen : assert property (s_q.strapDone |=> $stable(s_q.portEn))
        else $error("strap changed after capture");
    a_irq_until_ack : assert property ($fell(s_q.hostIrq) |-> $past(ackWr))
        else $error("host interrupt dropped without acknowledge");
    a_wide_irq_idle : assert property (s_q.wide |=> hostIrqOut)
        else $error("interrupt used in wide mode");
endmodule : hpp_host_port

// ===== hw/hpp_irq_regs.sv
`timescale 1ns/1ps
// ****************************************************************
// Sticky status, mask and the summary interrupt line.
// ****************************************************************
module hpp_irq_regs (
    input wire logic clk,
    input wire logic arst_n,
    hpp_evt_if.irqs eif
);
    import hpp_pkg::*;
    typedef struct packed {
        logic [NEV-1:0] status;
        logic [NEV-1:0] mask;
    } hpp_irq_s;
    hpp_irq_s s_q, s_d; // Whole state of the interrupt block.

    // A new event wins over a write-one-to-clear in the same cycle.
    always_comb
    begin
        s_d = s_q;
        if (eif.wrStatus)
        begin
            s_d.status = s_q.status & ~eif.wdata;
        end
        s_d.status = s_d.status | eif.evt;
        if (eif.wrMask)
        begin
            s_d.mask = eif.wdata;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign eif.status = s_q.status;
    assign eif.mask = s_q.mask;
    assign eif.irq = |(s_q.status & s_q.mask);

    a_event_sets_sticky : assert property (@(posedge clk) disable iff (!arst_n)
        (eif.evt != '0) |=> ((eif.status & $past(eif.evt)) == $past(eif.evt)))
        else $error("event lost against a clear");
endmodule : hpp_irq_regs

// ===== hw/hpp_pkg.sv
// ****************************************************************
// Shared constants of the host port block.
// ****************************************************************
package hpp_pkg;
    // APB register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_HADDR = 8'h0c;
    localparam logic [7:0] OFF_TOHOST = 8'h10;
    localparam logic [7:0] OFF_FROMHOST = 8'h14;
    localparam logic [7:0] OFF_GPIO = 8'h18;
    // Control register fields.
    localparam int CTRL_HOLDER = 0;
    localparam int CTRL_HOSTIRQ = 1;
    localparam int CTRL_PORTEN = 2;
    localparam int CTRL_WIDE = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // GPIO register fields: output, direction, pin level.
    localparam int GPIO_OUT_LSB = 0;
    localparam int GPIO_DIR_LSB = 8;
    localparam int GPIO_IN_LSB = 16;
    // Event bits of the status and mask registers.
    localparam int NEV = 4;
    localparam int EV_HWRITE = 0;
    localparam int EV_HREAD = 1;
    localparam int EV_ACK = 2;
    localparam int EV_ADDR = 3;
    // Host register selection codes.
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_DATA = 2'h1;
    localparam logic [1:0] SEL_ADDR = 2'h2;
    // Host control register: writing a one here acknowledges the interrupt.
    localparam int HCTRL_ACK = 2;
    // Busy time after each host strobe.
    localparam int CLK_PERIOD_PS = 4000;
    localparam int BUSY_TIME_PS = 12000;
    localparam int BUSY_CYC = (BUSY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : hpp_pkg

// ===== tb/hpp_host_model.sv
`timescale 1ns/1ps
// ****
// Host model: drives the control pins and resolves the data wire.
// ****
module hpp_host_model (
    input wire logic clk,
    input wire logic [7:0] dOut,
    input wire logic [7:0] dOeN,
    input wire logic hold,
    input wire logic [7:0] holdLvl,
    input wire logic rdy,
    output logic [7:0] bus,
    output logic [1:0] sel,
    output logic bFlag,
    output logic csN,
    output logic stbAN,
    output logic stbBN,
    output logic alsN,
    output logic rnw
);
    logic hDrv = 1'b0; // Host drives the wire.
    logic [7:0] hVal = 8'h00; // Byte the host drives.
    logic [7:0] last = 8'h00; // Wire level one cycle ago.
    initial {sel, bFlag, csN, stbAN, stbBN, alsN, rnw} = 8'hff;
    // Undriven, unheld pins toggle so stale data never passes.
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            bus[i] = !dOeN[i] ? dOut[i] : hDrv ? hVal[i] : hold ? holdLvl[i] : ~last[i];
        end
    end
    always @(posedge clk) last <= bus;
    task automatic xfer(input logic rd, input logic [1:0] s, input logic f,
        input logic [7:0] wv, output logic [7:0] rv, output logic midRdy);
        while (rdy !== 1'b1)
        begin
            @(posedge clk);
        end
        sel <= s;
        bFlag <= f;
        rnw <= rd;
        csN <= 1'b0;
        hVal <= wv;
        hDrv <= !rd;
        stbAN <= !rd;
        stbBN <= rd;
        repeat (3) @(posedge clk);
        rv = bus;
        midRdy = rdy;
        csN <= 1'b1;
        stbAN <= 1'b1;
        stbBN <= 1'b1;
        hDrv <= 1'b0;
        @(posedge clk);
    endtask : xfer
    // Address byte latched by the address strobe.
    task automatic latch(input logic f, input logic [7:0] v);
        bFlag <= f;
        hVal <= v;
        hDrv <= 1'b1;
        csN <= 1'b0;
        @(posedge clk);
        alsN <= 1'b0;
        repeat (2) @(posedge clk);
        alsN <= 1'b1;
        csN <= 1'b1;
        hDrv <= 1'b0;
        @(posedge clk);
    endtask : latch
endmodule : hpp_host_model

// ===== tb/tb_host_port_pin_interface.sv
`timescale 1ns/1ps
// ****
// Bench of the host port block.
// ****
module tb_host_port_pin_interface;
    import hpp_pkg::*;
    logic clk = 1'b0, arst_n = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, dOut, dOeN, hLvl, bus;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [1:0] sel;
    logic pready, pslverr, irq, hEn, bFlag, csN, sAN, sBN, alsN, rnw, rdy, rdyOeN;
    logic hirq, hirqOeN, pullupEn, err, mid, floatN = 1'b1;
    logic strapPort = 1'b1, strapWide = 1'b0; // Strap levels seen at reset release.
    logic [7:0] b;
    int mismatches = 0, samples_checked = 0;
    always #2 clk = ~clk;
    hpp_host_port DUT (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .hostDataIn(bus),
        .hostDataOut(dOut), .hostDataOeN(dOeN), .holderEn(hEn), .holderLevel(hLvl),
        .hostRegisterSelect0(sel[0]), .hostRegisterSelect1(sel[1]),
        .byteOrderFlag(bFlag), .portSelectN(csN), .hostStrobeAN(sAN),
        .hostStrobeBN(sBN), .addrLatchStrobeN(alsN), .hostReadNotWrite(rnw),
        .portReadyOut(rdy), .portReadyOeN(rdyOeN), .hostIrqOut(hirq),
        .hostIrqOeN(hirqOeN), .floatAllN(floatN), .portEnableStrap(strapPort),
        .wideModeStrap(strapWide), .pullupEn(pullupEn));
    hpp_host_model host (.clk(clk), .dOut(dOut), .dOeN(dOeN), .hold(hEn),
        .holdLvl(hLvl), .rdy(rdy), .bus(bus), .sel(sel), .bFlag(bFlag), .csN(csN),
        .stbAN(sAN), .stbBN(sBN), .alsN(alsN), .rnw(rnw));
    // Compares one value and counts it.
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    // One APB transfer; a spare edge keeps back-to-back calls clean.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Reset values of the pins, then pull-ups off once the port is strapped on.
    task automatic t_reset;
        check("ready", rdy, 1);
        check("hirq", hirq, 1);
        check("oen", dOeN, 8'hff);
        check("holder", hEn, 0);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("pullup", pullupEn, 0);
    endtask : t_reset
    // Forced float releases every output.
    task automatic t_float;
        floatN <= 1'b0;
        @(posedge clk);
        check("foen", {dOeN, rdyOeN, hirqOeN}, 10'h3ff);
        floatN <= 1'b1;
        @(posedge clk);
    endtask : t_float
    // Host reads both bytes; holders keep the last byte afterwards.
    task automatic t_read;
        apb(1, OFF_CTRL, 32'h1);
        check("hen", hEn, 1);
        apb(1, OFF_TOHOST, 32'ha55a);
        host.xfer(1, SEL_DATA, 0, 8'h00, b, mid);
        check("rdhi", b, 8'ha5);
        check("busy", mid, 0);
        host.xfer(1, SEL_DATA, 1, 8'h00, b, mid);
        check("rdlo", b, 8'h5a);
        repeat (3) @(posedge clk);
        check("hold", hLvl, 8'h5a);
        check("idle", dOeN, 8'hff);
    endtask : t_read
    // Host writes a word and latches an address.
    task automatic t_write;
        host.xfer(0, SEL_DATA, 0, 8'h12, b, mid);
        host.xfer(0, SEL_DATA, 1, 8'h34, b, mid);
        apb(0, OFF_FROMHOST, 0);
        check("from", r, 32'h1234);
        host.latch(0, 8'h9a);
        host.latch(1, 8'hbc);
        apb(0, OFF_HADDR, 0);
        check("haddr", r, 32'h9abc);
    endtask : t_write
    // Host interrupt raised, held, acknowledged; status, mask, clear.
    task automatic t_irq;
        apb(1, OFF_MASK, 32'h1 << EV_ACK);
        apb(1, OFF_STATUS, 32'hf);
        apb(1, OFF_CTRL, 32'h3);
        repeat (6) @(posedge clk);
        check("hold", {hirq, irq}, 2'b00);
        host.xfer(0, SEL_CTRL, 1, 8'h04, b, mid);
        @(posedge clk);
        check("ack", {hirq, irq}, 2'b11);
        apb(1, OFF_STATUS, 32'h1 << EV_ACK);
        check("clr", irq, 0);
        apb(0, 8'h40, 0);
        check("bad", {31'h0, err}, 32'h1);
        check("badrd", r, 32'h0);
        check("pready", pready, 1);
    endtask : t_irq
    // Mid-run resets: GPIO with the port strapped off, then wide mode with it on.
    task automatic t_straps;
        strapPort <= 1'b0;
        strapWide <= 1'b1;
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("pullon", pullupEn, 1);
        apb(1, OFF_GPIO, 32'h0000_ff3c);
        check("gpoen", dOeN, 8'h00);
        check("gpout", dOut, 8'h3c);
        apb(1, OFF_CTRL, 32'h2);
        check("wirq", hirq, 1);
        strapPort <= 1'b1;
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        host.xfer(0, SEL_ADDR, 0, 8'h77, b, mid);
        apb(0, OFF_FROMHOST, 0);
        check("wide", r, 32'h77);
        apb(0, OFF_HADDR, 0);
        check("wadr", r, 32'h0);
    endtask : t_straps
    // Prints the counts and the verdict.
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        arst_n <= 1'b0;
        repeat (8) @(posedge clk);
        t_reset;
        t_float;
        t_read;
        t_write;
        t_irq;
        t_straps;
        complete_run;
    end
    initial
    begin
        #20000;
        mismatches++;
        complete_run;
    end
endmodule : tb_host_port_pin_interface
